// [ssd_pkg.sv]
// Package for the sensorless stall detector: register offsets, field layouts and reset values.
// Assumes a single AHB-Lite slave with 32-bit words at aligned byte offsets.
package ssd_pkg;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_OFFSET    = 8'h04;
	localparam logic [7:0]  ADDR_TLOW      = 8'h08;
	localparam logic [7:0]  ADDR_UPPER_VELOCITY_LIMIT_PERIOD     = 8'h0C;
	localparam logic [7:0]  ADDR_THRS2     = 8'h10;
	localparam logic [7:0]  ADDR_READING   = 8'h14;
	localparam logic [7:0]  ADDR_READING2  = 8'h18;
	localparam logic [7:0]  ADDR_STATUS    = 8'h1C;
	localparam logic [7:0]  ADDR_MASK      = 8'h20;
	localparam int          CTRL_FILT      = 0;
	localparam int          CTRL_STOP      = 1;
	localparam int          CTRL_FILT2     = 2;
	localparam int          ST_STOP        = 0;
	localparam int          ST_STALL2      = 1;
	localparam int          ST_UPDATE      = 2;
	localparam int          NUM_EVENTS     = 3;
	localparam logic [9:0]  READING_MAX    = 10'h3FF;
	localparam logic [9:0]  READING_RST    = 10'h3FF;
	localparam logic [8:0]  READING2_RST   = 9'h1FE;
	localparam logic [19:0] TLOW_RST       = 20'h0_0000;
	localparam logic [19:0] UPPER_VELOCITY_LIMIT_PERIOD_RST      = 20'h0_0000;
	localparam logic [7:0]  THRS2_RST      = 8'h00;
	localparam logic [1:0]  AVG_COUNT      = 2'h3;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
endpackage

// [ssd_stall_detect.sv]
// Stall detection with per-full-step load reading, offset, averaging and velocity window.
// Assumes a full-step strobe, step period and raw measurements on the same clock as hclk.
// Overview of operation
// - The load reading is refreshed once per full step, not per clock or microstep.
// - With the filter enabled the reading is the average of four measurements.
// - The load offset is a signed two's-complement value added to the raw measurement.
// - With stop-on-stall enabled, a zero reading stops the ramp generator.
// - After a stall stop the motor stays stopped until stop-on-stall or the flag is cleared.
// - Stall detection is suppressed below the lower velocity limit.
// - Stall detection is suppressed above the upper velocity limit.
// - Both readings are high at low load and fall toward low values at high load.
// - The second reading detects a stall by comparison against a threshold, not an offset.
// - The first reading is unsigned in the range 0 to 1023.
// - With the filter on, the reading updates once per four full steps.
// - The second stall output rises when its reading falls below the threshold of 0 to 255.
//
// The address map and register access over AHB-Lite were left to the implementer.
module ssd_stall_detect #(
	parameter int TW = 20
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        full_step,
	input  wire logic [TW-1:0] step_period,
	input  wire logic [9:0]  raw_load,
	input  wire logic [8:0]  raw_load_gen2,
	output logic             motor_stop,
	output logic             stall_out_gen2,
	output logic             irq
);
	typedef struct packed {
		logic        wr_pend;
		logic        rd_pend;
		logic [7:0]  addr;
		logic [31:0] rdata;
		logic        filt_en;
		logic        stop_en;
		logic        filt2_en;
		logic [6:0]  offset;
		logic [TW-1:0] tlow;
		logic [TW-1:0] upper_velocity_limit_period;
		logic [7:0]  thrs2;
		logic [9:0]  reading;
		logic [8:0]  reading2;
		logic [11:0] acc;
		logic [10:0] acc2;
		logic [1:0]  cnt;
		logic        stall2;
		logic [ssd_pkg::NUM_EVENTS-1:0] status;
		logic [ssd_pkg::NUM_EVENTS-1:0] mask;
	} ssd_state_t;

	ssd_state_t s_q;
	ssd_state_t s_d;

	logic signed [11:0] shifted;
	logic [9:0]  meas;
	logic        in_window;
	logic        update;
	logic        filt_done;
	logic [9:0]  new_reading;
	logic [8:0]  new_reading2;
	logic [ssd_pkg::NUM_EVENTS-1:0] ev;
	logic [ssd_pkg::NUM_EVENTS-1:0] clr;
	logic [31:0] rd_mux;

	always_comb
	begin
		// Offset is sign-extended before the add so negative offsets lower the value.
		shifted = $signed({2'b00, raw_load}) + $signed({{5{s_q.offset[6]}}, s_q.offset});
		if (shifted < 0)
		begin
			meas = 10'h000;
		end
		else if (shifted > $signed({2'b00, ssd_pkg::READING_MAX}))
		begin
			meas = ssd_pkg::READING_MAX;
		end
		else
		begin
			meas = shifted[9:0];
		end
		// A longer period means a slower motor; a zero upper limit disables its side of the window, a zero tlow disables all detection.
		in_window = (step_period <= s_q.tlow) && (step_period > s_q.upper_velocity_limit_period);
		filt_done = full_step && (s_q.cnt == ssd_pkg::AVG_COUNT);
		update = full_step && (!s_q.filt_en || filt_done);
		new_reading = s_q.filt_en ? s_q.acc[11:2] + 10'(0) : meas;
		if (s_q.filt_en)
		begin
			new_reading = 10'((s_q.acc + {2'b00, meas}) >> 2);
		end
		new_reading2 = raw_load_gen2;
		if (s_q.filt2_en)
		begin
			new_reading2 = 9'((s_q.acc2 + {2'b00, raw_load_gen2}) >> 2);
		end
	end

	always_comb
	begin
		s_d = s_q;
		ev = '0;
		clr = '0;
		rd_mux = 32'h0000_0000;
		// Read data is decoded in the address phase so that it stands for the whole data phase.
		if (haddr == ssd_pkg::ADDR_CTRL)
		begin
			rd_mux = {29'h0, s_q.filt2_en, s_q.stop_en, s_q.filt_en};
		end
		else if (haddr == ssd_pkg::ADDR_OFFSET)
		begin
			rd_mux = {25'h0, s_q.offset};
		end
		else if (haddr == ssd_pkg::ADDR_TLOW)
		begin
			rd_mux = 32'(s_q.tlow);
		end
		else if (haddr == ssd_pkg::ADDR_UPPER_VELOCITY_LIMIT_PERIOD)
		begin
			rd_mux = 32'(s_q.upper_velocity_limit_period);
		end
		else if (haddr == ssd_pkg::ADDR_THRS2)
		begin
			rd_mux = {24'h0, s_q.thrs2};
		end
		else if (haddr == ssd_pkg::ADDR_READING)
		begin
			rd_mux = {22'h0, s_q.reading};
		end
		else if (haddr == ssd_pkg::ADDR_READING2)
		begin
			rd_mux = {23'h0, s_q.reading2};
		end
		else if (haddr == ssd_pkg::ADDR_STATUS)
		begin
			rd_mux = {29'h0, s_q.status};
		end
		else if (haddr == ssd_pkg::ADDR_MASK)
		begin
			rd_mux = {29'h0, s_q.mask};
		end
		if (hsel && hready && (htrans == ssd_pkg::HTRANS_NONSEQ) && !hwrite)
		begin
			s_d.rdata = rd_mux;
		end
		// Registers are written in the data phase one cycle after the address phase.
		if (s_q.wr_pend)
		begin
			if (s_q.addr == ssd_pkg::ADDR_CTRL)
			begin
				s_d.filt_en  = hwdata[ssd_pkg::CTRL_FILT];
				s_d.stop_en  = hwdata[ssd_pkg::CTRL_STOP];
				s_d.filt2_en = hwdata[ssd_pkg::CTRL_FILT2];
			end
			else if (s_q.addr == ssd_pkg::ADDR_OFFSET)
			begin
				s_d.offset = hwdata[6:0];
			end
			else if (s_q.addr == ssd_pkg::ADDR_TLOW)
			begin
				s_d.tlow = hwdata[TW-1:0];
			end
			else if (s_q.addr == ssd_pkg::ADDR_UPPER_VELOCITY_LIMIT_PERIOD)
			begin
				s_d.upper_velocity_limit_period = hwdata[TW-1:0];
			end
			else if (s_q.addr == ssd_pkg::ADDR_THRS2)
			begin
				s_d.thrs2 = hwdata[7:0];
			end
			else if (s_q.addr == ssd_pkg::ADDR_STATUS)
			begin
				clr = hwdata[ssd_pkg::NUM_EVENTS-1:0];
			end
			else if (s_q.addr == ssd_pkg::ADDR_MASK)
			begin
				s_d.mask = hwdata[ssd_pkg::NUM_EVENTS-1:0];
			end
		end
		s_d.wr_pend = hsel && hready && (htrans == ssd_pkg::HTRANS_NONSEQ) && hwrite;
		s_d.rd_pend = hsel && hready && (htrans == ssd_pkg::HTRANS_NONSEQ) && !hwrite;
		if (hsel && hready && (htrans == ssd_pkg::HTRANS_NONSEQ))
		begin
			s_d.addr = haddr;
		end
		// Measurement pipeline advances only on the full-step strobe.
		if (full_step)
		begin
			// The group counter restarts while both filters are off, so the first average spans four steps.
			s_d.cnt = (s_q.filt_en || s_q.filt2_en) ? s_q.cnt + 2'h1 : 2'h0;
			s_d.acc = filt_done ? 12'h000 : s_q.acc + {2'b00, meas};
			s_d.acc2 = filt_done ? 11'h000 : s_q.acc2 + {2'b00, raw_load_gen2};
			if (!s_q.filt_en)
			begin
				s_d.acc = 12'h000;
			end
			if (!s_q.filt2_en)
			begin
				s_d.acc2 = 11'h000;
			end
		end
		if (update)
		begin
			s_d.reading = new_reading;
		end
		if (full_step && (!s_q.filt2_en || filt_done))
		begin
			s_d.reading2 = new_reading2;
			s_d.stall2 = (new_reading2 < {1'b0, s_q.thrs2}) && in_window;
		end
		ev[ssd_pkg::ST_STOP] = update && s_q.stop_en && in_window && (new_reading == 10'h000);
		ev[ssd_pkg::ST_STALL2] = s_d.stall2 && !s_q.stall2;
		ev[ssd_pkg::ST_UPDATE] = update;
		// A new event in the clearing cycle wins over the clear.
		s_d.status = (s_q.status & ~clr) | ev;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_q <= '{wr_pend: 1'b0, rd_pend: 1'b0, addr: 8'h00, rdata: 32'h0000_0000,
				filt_en: 1'b0, stop_en: 1'b0, filt2_en: 1'b0, offset: 7'h00,
				tlow: TW'(ssd_pkg::TLOW_RST), upper_velocity_limit_period: TW'(ssd_pkg::UPPER_VELOCITY_LIMIT_PERIOD_RST),
				thrs2: ssd_pkg::THRS2_RST, reading: ssd_pkg::READING_RST,
				reading2: ssd_pkg::READING2_RST, acc: 12'h000, acc2: 11'h000, cnt: 2'h0,
				stall2: 1'b0, status: '0, mask: '0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Stop holds while the latched flag and stop-on-stall are both present.
	assign motor_stop = s_q.stop_en && s_q.status[ssd_pkg::ST_STOP];
	assign stall_out_gen2 = s_q.stall2;
	assign irq = |(s_q.status & s_q.mask);

	a_reading_step: assert property (@(posedge hclk) disable iff (!hresetn)
		!$past(update) |-> $stable(s_q.reading))
		else $error("reading changed without a full-step update");
	a_filter_rate: assert property (@(posedge hclk) disable iff (!hresetn)
		(full_step && s_q.filt_en && s_q.cnt != ssd_pkg::AVG_COUNT) |-> !update)
		else $error("filtered reading updated before four steps");
	a_stall_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		(update && s_q.stop_en && in_window && new_reading == 10'h000)
		|=> s_q.status[ssd_pkg::ST_STOP])
		else $error("stall flag not set on zero reading");
	a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		(motor_stop && !s_q.wr_pend) |=> motor_stop)
		else $error("motor restarted without software action");
	a_low_window: assert property (@(posedge hclk) disable iff (!hresetn)
		(step_period > s_q.tlow) |-> !ev[ssd_pkg::ST_STOP])
		else $error("stall detected below lower velocity");
	a_high_window: assert property (@(posedge hclk) disable iff (!hresetn)
		(step_period <= s_q.upper_velocity_limit_period) |-> !ev[ssd_pkg::ST_STOP])
		else $error("stall detected above upper velocity");
	a_gen2_compare: assert property (@(posedge hclk) disable iff (!hresetn)
		(full_step && (!s_q.filt2_en || filt_done))
		|=> (stall_out_gen2 == ((s_q.reading2 < {1'b0, $past(s_q.thrs2)}) && $past(in_window))))
		else $error("gen2 stall without reading below threshold");
	a_offset_sign: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.offset[6] && !s_q.filt_en && update && raw_load == 10'h000) |=> s_q.reading == 10'h000)
		else $error("negative offset did not lower reading");
endmodule

// [ssd_motor_model.sv]
// Motor side model: one full-step pulse every GAP cycles while run is high.
// Assumes the bench sets the loads between pulses, on hclk.
module ssd_motor_model #(
	parameter int GAP = 6
) (
	input  wire logic       hclk,
	input  wire logic       run,
	input  wire logic [9:0] load,
	input  wire logic [8:0] load2,
	output logic            full_step,
	output logic      [9:0] raw_load,
	output logic      [8:0] raw_load_gen2
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial full_step = 1'b0;
	always @(posedge hclk)
	begin
		cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
		full_step <= run && cnt == 0;
	end
	// Samples are only valid with the pulse, so a sampler that ignores it sees junk.
	assign raw_load = full_step ? load : ~load;
	assign raw_load_gen2 = full_step ? load2 : ~load2;
endmodule

// [tb.sv]
// Bench for the stall detector: AHB-Lite master tasks and a motor model.
// Assumes zero or more wait states; hready is looped back from hreadyout.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 0;
	logic        hresetn = 0;
	logic        hsel = 0;
	logic        hwrite = 0;
	logic        run = 0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [19:0] step_period = 20'h0_0010;
	logic [9:0]  load = 10'h000;
	logic [8:0]  load2 = 9'h000;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [9:0]  raw_load;
	logic [8:0]  raw_load_gen2;
	logic        hreadyout, full_step, motor_stop, stall_out_gen2, irq;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	always #20 hclk = ~hclk;
	ssd_stall_detect ssd_stall_detect_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
		.full_step(full_step), .step_period(step_period), .raw_load(raw_load),
		.raw_load_gen2(raw_load_gen2), .motor_stop(motor_stop),
		.stall_out_gen2(stall_out_gen2), .irq(irq));
	ssd_motor_model ssd_motor_model_inst (.hclk(hclk), .run(run), .load(load), .load2(load2),
		.full_step(full_step), .raw_load(raw_load), .raw_load_gen2(raw_load_gen2));
	task automatic give_verdict();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic steps(input int n);
		run <= 1'b1;
		repeat (n)
		begin
			@(posedge hclk);
			while (full_step !== 1'b1) @(posedge hclk);
		end
		run <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic t_offset();
		wr(ssd_pkg::ADDR_OFFSET, 32'h0000_007D);
		load <= 10'h00A;
		steps(1);
		rdchk(ssd_pkg::ADDR_READING, 32'h0000_0007);
		load <= 10'h000;
		steps(1);
		rdchk(ssd_pkg::ADDR_READING, 32'h0000_0000);
		wr(ssd_pkg::ADDR_OFFSET, 32'h0000_0005);
		load <= 10'h3FC;
		steps(1);
		rdchk(ssd_pkg::ADDR_READING, 32'h0000_03FF);
		wr(ssd_pkg::ADDR_OFFSET, 32'h0000_0000);
	endtask
	task automatic t_filter();
		wr(ssd_pkg::ADDR_CTRL, 32'h0000_0001);
		load <= 10'h064;
		steps(8);
		rdchk(ssd_pkg::ADDR_READING, 32'h0000_0064);
		load <= 10'h000;
		steps(1);
		rdchk(ssd_pkg::ADDR_READING, 32'h0000_0064);
		wr(ssd_pkg::ADDR_CTRL, 32'h0000_0000);
	endtask
	task automatic t_stall();
		wr(ssd_pkg::ADDR_TLOW, 32'h0000_0064);
		wr(ssd_pkg::ADDR_UPPER_VELOCITY_LIMIT_PERIOD, 32'h0000_0014);
		wr(ssd_pkg::ADDR_MASK, 32'h0000_0001);
		wr(ssd_pkg::ADDR_CTRL, 32'h0000_0002);
		step_period <= 20'h0_0065;
		steps(1);
		chk(motor_stop, 0);
		step_period <= 20'h0_0014;
		steps(1);
		chk(motor_stop, 0);
		step_period <= 20'h0_0064;
		steps(1);
		chk({irq, motor_stop}, 3);
		wr(ssd_pkg::ADDR_MASK, 32'h0000_0000);
		chk(irq, 0);
		wr(ssd_pkg::ADDR_MASK, 32'h0000_0001);
		load <= 10'h1F4;
		steps(1);
		chk({irq, motor_stop}, 3);
		wr(ssd_pkg::ADDR_STATUS, 32'h0000_0001);
		chk({irq, motor_stop}, 0);
		load <= 10'h000;
		step_period <= 20'h0_0015;
		steps(1);
		chk(motor_stop, 1);
		wr(ssd_pkg::ADDR_CTRL, 32'h0000_0000);
		chk(motor_stop, 0);
		wr(ssd_pkg::ADDR_STATUS, 32'h0000_0007);
	endtask
	task automatic t_gen2();
		wr(ssd_pkg::ADDR_THRS2, 32'h0000_0032);
		step_period <= 20'h0_0032;
		load2 <= 9'h031;
		steps(1);
		chk(stall_out_gen2, 1);
		rdchk(ssd_pkg::ADDR_READING2, 32'h0000_0031);
		load2 <= 9'h032;
		steps(1);
		chk(stall_out_gen2, 0);
	endtask
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(ssd_pkg::ADDR_READING, 32'h0000_03FF);
		rdchk(ssd_pkg::ADDR_READING2, 32'h0000_01FE);
		rdchk(8'h24, 32'h0000_0000);
		t_offset();
		t_filter();
		t_stall();
		t_gen2();
		give_verdict();
	end
endmodule
